// >>> design/bit_check_exec.v
/*
  Executes the bit test, the single-bound check and the paired-bound check.
  Takes an opcode and extension word, requests registers and memory
  operands from the fetch unit one at a time, returns new flags, a trap
  request with its vector, or an illegal-instruction pulse. APB slave
  for enable, status and counters. Assumes the fetch unit answers every
  operand request and that the caller holds no instruction while busy.
*/
`timescale 1ns/10ps
`include "bit_check_map.vh"
`default_nettype none

// Functional notes
// - register target: bit number modulo 32, any register bit selectable.
// - memory target: byte operation, bit number modulo 8.
// - bit number zero selects the least significant bit.
// - static form takes bit number from the extension word.
// - dynamic form reads bit number from data register in opcode.
// - zero flag set when tested bit is 0; other flags kept.
// - static form: opcode 15..6 is 0000100000, extension upper byte zero.
// - dynamic form: 15..12 zero, register in 11..9, 8..6 is 100.
// - long operation on data register, byte operation otherwise.
// - static form: data modes incl. pc-relative; no address-direct or immediate.
// - dynamic form additionally accepts immediate; rejects address-direct.
// - single-bound check treats operand as signed upper bound.
// - single-bound trap, vector 6, when register negative or above bound.
// - single-bound: N set if negative, cleared if above; X kept.
// - single-bound decode: 15..12 is 0100, size 11 word, 10 long.
// - paired-bound: fetch lower bound first, upper bound second.
// - byte/word on data register compares only its low part.
// - byte/word on address register sign-extends bounds, whole register.
// - paired-bound trap, vector 6, when outside; equal bounds allow one value.
// - paired-bound: Z when equal to a bound, C when out of range.
// - paired-bound sizes 00,01,10; extension holds register kind and number.
// - paired-bound accepts only control modes for bounds.
module bit_check_exec (
  // clock and reset
  input wire CLK_IN,
  input wire RST_IN,
  // apb slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  // instruction in
  input wire INSTR_VALID_IN,
  input wire [15:0] OPCODE_IN,
  input wire [15:0] EXT_WORD_IN,
  input wire [4:0] CCR_IN,
  output reg INSTR_READY_OUT,
  // operand requests
  output reg OPR_REQ_OUT,
  output reg OPR_MEM_OUT,
  output reg [3:0] OPR_REG_OUT,
  output reg [1:0] OPR_SIZE_OUT,
  output reg OPR_SECOND_OUT,
  input wire OPR_ACK_IN,
  input wire [31:0] OPR_DATA_IN,
  // results
  output reg DONE_OUT,
  output reg [4:0] CCR_OUT,
  output reg TRAP_OUT,
  output reg [7:0] TRAP_VECTOR_OUT,
  output reg ILLEGAL_OUT
);

  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_RDA = 6'b000010;
  localparam [5:0] S_RDB = 6'b000100;
  localparam [5:0] S_FLO = 6'b001000;
  localparam [5:0] S_FHI = 6'b010000;
  localparam [5:0] S_EXEC = 6'b100000;

  reg [5:0] state_reg;
  reg [15:0] op_reg;
  reg [15:0] ext_reg;
  reg [4:0] ccr_reg;
  reg [31:0] val_a_reg;
  reg [31:0] opnd_reg;
  reg [31:0] hi_reg;
  reg [31:0] ctrl_reg;
  reg [31:0] exec_count_reg;
  reg [31:0] trap_count_reg;
  reg last_trap_reg;
  reg last_illegal_reg;

  // decode of the incoming word
  wire [2:0] in_mode = OPCODE_IN[5:3];
  wire [2:0] in_rg = OPCODE_IN[2:0];
  wire is_bit_static = (OPCODE_IN[15:6] == `BIT_STATIC_PAT) &&
    (EXT_WORD_IN[15:8] == 8'h00);
  wire is_bit_dyn = (OPCODE_IN[15:12] == `BIT_DYN_HI) &&
    (OPCODE_IN[8:6] == `BIT_DYN_LO);
  wire is_sbc = (OPCODE_IN[15:12] == `SBC_HI) && (OPCODE_IN[6] == 1'b0) &&
    ((OPCODE_IN[8:7] == `SBC_SIZE_WORD) || (OPCODE_IN[8:7] == `SBC_SIZE_LONG));
  wire is_pbc = (OPCODE_IN[15:11] == `PBC_HI) && (OPCODE_IN[8:6] == `PBC_LO) &&
    (OPCODE_IN[10:9] != 2'h3) && (EXT_WORD_IN[11:0] == `PBC_EXT_LOW);

  // data modes without immediate
  wire ext_data_ok = (in_rg <= `EXT_PCREL_INDEX);
  wire data_ok = (in_mode != `MODE_AREG) &&
    ((in_mode != `MODE_EXT) || ext_data_ok);
  wire dyn_ok = data_ok ||
    ((in_mode == `MODE_EXT) && (in_rg == `EXT_IMM));
  wire ctrl_ok = (in_mode == `MODE_IND) || (in_mode == `MODE_DISP) ||
    (in_mode == `MODE_INDEX) || ((in_mode == `MODE_EXT) && ext_data_ok);

  wire known = is_bit_static | is_bit_dyn | is_sbc | is_pbc;
  wire mode_ok = is_bit_dyn ? dyn_ok : (is_pbc ? ctrl_ok : data_ok);
  wire enabled = ctrl_reg[`CTRL_ENABLE_BIT];
  wire take = INSTR_VALID_IN & INSTR_READY_OUT;

  // decode of the held word
  wire h_bit_static = (op_reg[15:6] == `BIT_STATIC_PAT);
  wire h_bit_dyn = (op_reg[15:12] == `BIT_DYN_HI) && (op_reg[8:6] == `BIT_DYN_LO);
  wire h_sbc = (op_reg[15:12] == `SBC_HI);
  wire h_pbc = ~(h_bit_static | h_bit_dyn | h_sbc);
  wire h_dreg = (op_reg[5:3] == `MODE_DREG);
  wire [1:0] pbc_size = op_reg[10:9];
  wire sbc_word = (op_reg[8:7] == `SBC_SIZE_WORD);

  // bit test
  wire [7:0] bit_num = h_bit_static ? ext_reg[7:0] : val_a_reg[7:0];
  wire [4:0] bit_idx = h_dreg ? bit_num[4:0] : {2'b00, bit_num[2:0]};
  wire tested_bit = opnd_reg[bit_idx];

  // single-bound check, signed
  wire [31:0] sbc_val = sbc_word ? {{16{val_a_reg[15]}}, val_a_reg[15:0]} : val_a_reg;
  wire [31:0] sbc_bnd = sbc_word ? {{16{opnd_reg[15]}}, opnd_reg[15:0]} : opnd_reg;
  wire sbc_neg = sbc_val[31];
  wire sbc_above = $signed(sbc_val) > $signed(sbc_bnd);

  // paired-bound check
  wire pbc_areg = ext_reg[15];
  wire lo_le_hi_uns = zx(opnd_reg, pbc_size) <= zx(hi_reg, pbc_size);
  wire pbc_signed_ext = pbc_areg | ~lo_le_hi_uns;
  wire [31:0] pbc_lo = pbc_signed_ext ? sx(opnd_reg, pbc_size) : zx(opnd_reg, pbc_size);
  wire [31:0] pbc_hi = pbc_signed_ext ? sx(hi_reg, pbc_size) : zx(hi_reg, pbc_size);
  wire [31:0] pbc_val = pbc_areg ? val_a_reg :
    (pbc_signed_ext ? sx(val_a_reg, pbc_size) : zx(val_a_reg, pbc_size));
  wire pbc_uns = (pbc_lo <= pbc_hi);
  wire pbc_below = pbc_uns ? (pbc_val < pbc_lo) : ($signed(pbc_val) < $signed(pbc_lo));
  wire pbc_above = pbc_uns ? (pbc_val > pbc_hi) : ($signed(pbc_val) > $signed(pbc_hi));
  wire pbc_out = pbc_below | pbc_above;
  wire pbc_equal = (pbc_val == pbc_lo) | (pbc_val == pbc_hi);

  function [31:0] sx;
    input [31:0] v;
    input [1:0] sz;
    case (sz)
      `SIZE_BYTE: sx = {{24{v[7]}}, v[7:0]};
      `SIZE_WORD: sx = {{16{v[15]}}, v[15:0]};
      default: sx = v;
    endcase
  endfunction

  function [31:0] zx;
    input [31:0] v;
    input [1:0] sz;
    case (sz)
      `SIZE_BYTE: zx = {24'h00_0000, v[7:0]};
      `SIZE_WORD: zx = {16'h0000, v[15:0]};
      default: zx = v;
    endcase
  endfunction

  // result flags and trap of the held instruction
  reg [4:0] res_ccr;
  reg res_trap;
  always @* begin
    res_ccr = ccr_reg;
    res_trap = 1'b0;
    if (h_bit_static | h_bit_dyn) begin
      res_ccr[`CCR_Z] = ~tested_bit;
    end else if (h_sbc) begin
      res_trap = sbc_neg | sbc_above;
      if (sbc_neg) begin
        res_ccr[`CCR_N] = 1'b1;
      end else if (sbc_above) begin
        res_ccr[`CCR_N] = 1'b0;
      end
    end else begin
      res_trap = pbc_out;
      res_ccr[`CCR_Z] = pbc_equal;
      res_ccr[`CCR_C] = pbc_out;
    end
  end

  // operand sequencing
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= S_IDLE;
      op_reg <= 16'h0000;
      ext_reg <= 16'h0000;
      ccr_reg <= 5'h00;
      val_a_reg <= 32'h0000_0000;
      opnd_reg <= 32'h0000_0000;
      hi_reg <= 32'h0000_0000;
      INSTR_READY_OUT <= 1'b0;
      OPR_REQ_OUT <= 1'b0;
      OPR_MEM_OUT <= 1'b0;
      OPR_REG_OUT <= 4'h0;
      OPR_SIZE_OUT <= 2'h0;
      OPR_SECOND_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      CCR_OUT <= 5'h00;
      TRAP_OUT <= 1'b0;
      TRAP_VECTOR_OUT <= 8'h00;
      ILLEGAL_OUT <= 1'b0;
      exec_count_reg <= 32'h0000_0000;
      trap_count_reg <= 32'h0000_0000;
      last_trap_reg <= 1'b0;
      last_illegal_reg <= 1'b0;
    end else begin
      DONE_OUT <= 1'b0;
      TRAP_OUT <= 1'b0;
      ILLEGAL_OUT <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          INSTR_READY_OUT <= enabled;
          if (take) begin
            INSTR_READY_OUT <= 1'b0;
            op_reg <= OPCODE_IN;
            ext_reg <= EXT_WORD_IN;
            ccr_reg <= CCR_IN;
            if (!known || !mode_ok) begin
              ILLEGAL_OUT <= 1'b1;
              last_illegal_reg <= 1'b1;
              INSTR_READY_OUT <= enabled;
            end else if (is_bit_static) begin
              OPR_REQ_OUT <= 1'b1;
              OPR_SECOND_OUT <= 1'b0;
              OPR_REG_OUT <= {1'b0, in_rg};
              if (in_mode == `MODE_DREG) begin
                OPR_MEM_OUT <= 1'b0;
                OPR_SIZE_OUT <= `SIZE_LONG;
                state_reg <= S_RDB;
              end else begin
                OPR_MEM_OUT <= 1'b1;
                OPR_SIZE_OUT <= `SIZE_BYTE;
                state_reg <= S_FLO;
              end
            end else begin
              OPR_REQ_OUT <= 1'b1;
              OPR_MEM_OUT <= 1'b0;
              OPR_SECOND_OUT <= 1'b0;
              OPR_SIZE_OUT <= `SIZE_LONG;
              OPR_REG_OUT <= is_pbc ? EXT_WORD_IN[15:12] :
                {1'b0, OPCODE_IN[11:9]};
              state_reg <= S_RDA;
            end
          end
        end
        S_RDA: begin
          if (OPR_ACK_IN) begin
            val_a_reg <= OPR_DATA_IN;
            OPR_SECOND_OUT <= 1'b0;
            OPR_REG_OUT <= {1'b0, op_reg[2:0]};
            if (h_pbc) begin
              OPR_MEM_OUT <= 1'b1;
              OPR_SIZE_OUT <= pbc_size;
              state_reg <= S_FLO;
            end else if (h_dreg) begin
              OPR_MEM_OUT <= 1'b0;
              OPR_SIZE_OUT <= `SIZE_LONG;
              state_reg <= S_RDB;
            end else begin
              OPR_MEM_OUT <= 1'b1;
              if (h_sbc) begin
                OPR_SIZE_OUT <= sbc_word ? `SIZE_WORD : `SIZE_LONG;
              end else begin
                OPR_SIZE_OUT <= `SIZE_BYTE;
              end
              state_reg <= S_FLO;
            end
          end
        end
        S_RDB: begin
          if (OPR_ACK_IN) begin
            opnd_reg <= OPR_DATA_IN;
            OPR_REQ_OUT <= 1'b0;
            state_reg <= S_EXEC;
          end
        end
        S_FLO: begin
          if (OPR_ACK_IN) begin
            opnd_reg <= OPR_DATA_IN;
            if (h_pbc) begin
              OPR_SECOND_OUT <= 1'b1;
              state_reg <= S_FHI;
            end else begin
              OPR_REQ_OUT <= 1'b0;
              state_reg <= S_EXEC;
            end
          end
        end
        S_FHI: begin
          if (OPR_ACK_IN) begin
            hi_reg <= OPR_DATA_IN;
            OPR_REQ_OUT <= 1'b0;
            OPR_SECOND_OUT <= 1'b0;
            state_reg <= S_EXEC;
          end
        end
        S_EXEC: begin
          DONE_OUT <= 1'b1;
          CCR_OUT <= res_ccr;
          TRAP_OUT <= res_trap;
          TRAP_VECTOR_OUT <= res_trap ? `CHECK_VECTOR : 8'h00;
          last_trap_reg <= res_trap;
          last_illegal_reg <= 1'b0;
          exec_count_reg <= exec_count_reg + 32'h0000_0001;
          if (res_trap) begin
            trap_count_reg <= trap_count_reg + 32'h0000_0001;
          end
          INSTR_READY_OUT <= enabled;
          state_reg <= S_IDLE;
        end
        default: begin
          OPR_REQ_OUT <= 1'b0;
          INSTR_READY_OUT <= 1'b0;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // apb slave, one wait state
  wire apb_access = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
  wire addr_ok = (PADDR_IN == `OFS_CTRL) || (PADDR_IN == `OFS_STATUS) ||
    (PADDR_IN == `OFS_EXEC_COUNT) || (PADDR_IN == `OFS_TRAP_COUNT);
  reg [31:0] rd_mux;
  always @* begin
    case (PADDR_IN)
      `OFS_CTRL: rd_mux = ctrl_reg;
      `OFS_STATUS: rd_mux = {23'h00_0000, CCR_OUT, 1'b0, last_illegal_reg,
        last_trap_reg, ~state_reg[0]};
      `OFS_EXEC_COUNT: rd_mux = exec_count_reg;
      `OFS_TRAP_COUNT: rd_mux = trap_count_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_reg <= `CTRL_RESET;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
    end else begin
      PREADY_OUT <= apb_access;
      PSLVERR_OUT <= apb_access & ~addr_ok;
      if (apb_access) begin
        PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
      end
      if (apb_access && PWRITE_IN && (PADDR_IN == `OFS_CTRL)) begin
        ctrl_reg <= {31'h0000_0000, PWDATA_IN[`CTRL_ENABLE_BIT]};
      end
    end
  end

endmodule
`default_nettype wire

// >>> design/bit_check_map.vh
/*
  Constants for the bit-test and bounds-check execution block: register
  offsets, reset values, opcode patterns, size codes and flag positions.
  Assumes inclusion by bare name from design files.
*/
`ifndef BIT_CHECK_MAP_VH
`define BIT_CHECK_MAP_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_EXEC_COUNT 8'h08
`define OFS_TRAP_COUNT 8'h0C

// reset values and register bit positions
`define CTRL_RESET 32'h0000_0001
`define CTRL_ENABLE_BIT 0
`define STATUS_BUSY_BIT 0
`define STATUS_TRAP_BIT 1
`define STATUS_ILLEGAL_BIT 2
`define STATUS_CCR_LSB 4

// flag positions in the condition code byte
`define CCR_X 4
`define CCR_N 3
`define CCR_Z 2
`define CCR_V 1
`define CCR_C 0

// exception vector of a failed bounds check
`define CHECK_VECTOR 8'h06

// opcode patterns
`define BIT_STATIC_PAT 10'h020
`define BIT_DYN_HI 4'h0
`define BIT_DYN_LO 3'h4
`define SBC_HI 4'h4
`define PBC_HI 5'h00
`define PBC_LO 3'h0
`define PBC_EXT_LOW 12'h800

// effective address modes and special registers of mode 7
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_IND 3'h2
`define MODE_POST 3'h3
`define MODE_PRE 3'h4
`define MODE_DISP 3'h5
`define MODE_INDEX 3'h6
`define MODE_EXT 3'h7
`define EXT_PCREL_INDEX 3'h3
`define EXT_IMM 3'h4

// operation sizes
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define SBC_SIZE_WORD 2'h3
`define SBC_SIZE_LONG 2'h2

`endif

// >>> verif/bit_check_exec_assertions.sv
/* Checker for bit_check_exec: decode answers, request order and results.
   Bound to the design's ports; sees nothing inside the design. */
`timescale 1ns/10ps
`default_nettype none
`include "bit_check_map.vh"
module bit_check_exec_chk (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // instruction
  input wire logic INSTR_VALID_IN,
  input wire logic [15:0] OPCODE_IN,
  input wire logic [15:0] EXT_WORD_IN,
  input wire logic [4:0] CCR_IN,
  input wire logic INSTR_READY_OUT,
  // operand fetch
  input wire logic OPR_REQ_OUT,
  input wire logic OPR_MEM_OUT,
  input wire logic [3:0] OPR_REG_OUT,
  input wire logic [1:0] OPR_SIZE_OUT,
  input wire logic OPR_SECOND_OUT,
  input wire logic OPR_ACK_IN,
  // results
  input wire logic DONE_OUT,
  input wire logic [4:0] CCR_OUT,
  input wire logic TRAP_OUT,
  input wire logic [7:0] TRAP_VECTOR_OUT,
  input wire logic ILLEGAL_OUT
);
  logic [15:0] op_q;
  logic [15:0] ext_q;
  logic [4:0] ccr_q;
  wire take = INSTR_VALID_IN && INSTR_READY_OUT;
  wire is_bit = op_q[15:12] == 4'h0 && (op_q[8:6] == `BIT_DYN_LO || op_q[15:6] == `BIT_STATIC_PAT);
  wire is_pbc = op_q[15:11] == `PBC_HI && op_q[8:6] == `PBC_LO;
  // instruction fields held for the whole execution
  always @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      op_q <= 16'h0000;
      ext_q <= 16'h0000;
      ccr_q <= 5'h00;
    end else if (take) begin
      op_q <= OPCODE_IN;
      ext_q <= EXT_WORD_IN;
      ccr_q <= CCR_IN;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_lower_acked;
    OPR_REQ_OUT && OPR_MEM_OUT && !OPR_SECOND_OUT && OPR_ACK_IN && is_pbc;
  endsequence
  sequence s_upper_req;
    OPR_REQ_OUT && OPR_MEM_OUT && OPR_SECOND_OUT && OPR_SIZE_OUT == op_q[10:9];
  endsequence
  sequence s_last_ack;
    OPR_REQ_OUT && OPR_ACK_IN ##1 !OPR_REQ_OUT;
  endsequence
  a_take_answer: assert property (take |=> OPR_REQ_OUT || ILLEGAL_OUT)
    else $error("taken instruction got no answer");
  a_illegal_quiet: assert property (ILLEGAL_OUT |-> !OPR_REQ_OUT && !DONE_OUT)
    else $error("illegal encoding fetched or finished");
  a_trap_vector: assert property (TRAP_OUT |->
    DONE_OUT && TRAP_VECTOR_OUT == `CHECK_VECTOR)
    else $error("trap without done or with wrong vector");
  a_req_hold: assert property (OPR_REQ_OUT && !OPR_ACK_IN |=> OPR_REQ_OUT
    && $stable(OPR_MEM_OUT) && $stable(OPR_REG_OUT) && $stable(OPR_SIZE_OUT)
    && $stable(OPR_SECOND_OUT))
    else $error("operand request changed before ack");
  a_bit_flags: assert property (DONE_OUT && is_bit |-> !TRAP_OUT
    && CCR_OUT[4:3] == ccr_q[4:3] && CCR_OUT[1:0] == ccr_q[1:0])
    else $error("bit test touched flags other than zero");
  a_x_kept: assert property (DONE_OUT |-> CCR_OUT[4] == ccr_q[4])
    else $error("extend flag changed");
  a_bit_size: assert property (OPR_REQ_OUT && is_bit |->
    OPR_SIZE_OUT == (OPR_MEM_OUT ? `SIZE_BYTE : `SIZE_LONG))
    else $error("bit test operand size wrong");
  a_pbc_first: assert property ($rose(OPR_REQ_OUT) && is_pbc |->
    !OPR_MEM_OUT && OPR_REG_OUT == ext_q[15:12] && OPR_SIZE_OUT == `SIZE_LONG)
    else $error("paired check did not read its register first");
  a_bound_order: assert property (s_lower_acked |=> s_upper_req)
    else $error("upper bound not requested after lower");
  a_done_timely: assert property (s_last_ack |-> ##[0:2] DONE_OUT)
    else $error("no result after last operand");
endmodule
bind bit_check_exec bit_check_exec_chk i_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .INSTR_VALID_IN(INSTR_VALID_IN), .OPCODE_IN(OPCODE_IN), .EXT_WORD_IN(EXT_WORD_IN),
  .CCR_IN(CCR_IN), .INSTR_READY_OUT(INSTR_READY_OUT), .OPR_REQ_OUT(OPR_REQ_OUT),
  .OPR_MEM_OUT(OPR_MEM_OUT), .OPR_REG_OUT(OPR_REG_OUT), .OPR_SIZE_OUT(OPR_SIZE_OUT),
  .OPR_SECOND_OUT(OPR_SECOND_OUT), .OPR_ACK_IN(OPR_ACK_IN), .DONE_OUT(DONE_OUT),
  .CCR_OUT(CCR_OUT), .TRAP_OUT(TRAP_OUT), .TRAP_VECTOR_OUT(TRAP_VECTOR_OUT),
  .ILLEGAL_OUT(ILLEGAL_OUT));
`default_nettype wire

// >>> verif/operand_fetch_model.sv
/* Operand fetch model: answers each request from a register file or a
   bound pair, promptly or after two idle cycles. Bench fills the tables. */
`timescale 1ns/10ps
`default_nettype none
module operand_fetch_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // request side
  input wire logic req_in,
  input wire logic mem_in,
  input wire logic [3:0] reg_in,
  input wire logic second_in,
  input wire logic slow_in,
  // answer side
  output logic ack_out,
  output logic [31:0] data_out
);
  logic [31:0] regs [0:15];
  logic [31:0] mem_lo;
  logic [31:0] mem_hi;
  int idle;
  // off-answer data flips every cycle so stale values never pass
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      data_out <= 32'h0000_0000;
      idle <= 0;
    end else if (req_in && !ack_out && idle >= (slow_in ? 2 : 0)) begin
      ack_out <= 1'b1;
      data_out <= mem_in ? (second_in ? mem_hi : mem_lo) : regs[reg_in];
      idle <= 0;
    end else begin
      ack_out <= 1'b0;
      data_out <= ~data_out;
      idle <= req_in ? idle + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_bit_check_exec.sv
/* Bench for bit_check_exec: bit tests, bound checks, illegal forms, APB.
   Operand fetch comes from operand_fetch_model. */
`timescale 1ns/10ps
`default_nettype none
`include "bit_check_map.vh"
module tb_bit_check_exec;
  logic CLK_IN = 0, RST_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
  logic [7:0] PADDR_IN = 8'h00;
  logic [31:0] PWDATA_IN = 32'h0000_0000;
  logic [31:0] PRDATA_OUT, OPR_DATA_IN;
  logic PREADY_OUT, PSLVERR_OUT, INSTR_READY_OUT, OPR_REQ_OUT, OPR_MEM_OUT, OPR_SECOND_OUT;
  logic INSTR_VALID_IN = 0, OPR_ACK_IN, DONE_OUT, TRAP_OUT, ILLEGAL_OUT, slow = 0;
  logic [15:0] OPCODE_IN = 16'h0000, EXT_WORD_IN = 16'h0000;
  logic [4:0] CCR_IN = 5'h00, CCR_OUT, g_ccr;
  logic [3:0] OPR_REG_OUT;
  logic [1:0] OPR_SIZE_OUT;
  logic [7:0] TRAP_VECTOR_OUT, g_vec;
  logic g_done, g_ill, g_trap, er;
  logic [31:0] rd;
  int checks = 0, bad_count = 0, n_done = 0, n_trap = 0;
  bit_check_exec i_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .INSTR_VALID_IN(INSTR_VALID_IN), .OPCODE_IN(OPCODE_IN), .EXT_WORD_IN(EXT_WORD_IN),
    .CCR_IN(CCR_IN), .INSTR_READY_OUT(INSTR_READY_OUT), .OPR_REQ_OUT(OPR_REQ_OUT),
    .OPR_MEM_OUT(OPR_MEM_OUT), .OPR_REG_OUT(OPR_REG_OUT), .OPR_SIZE_OUT(OPR_SIZE_OUT),
    .OPR_SECOND_OUT(OPR_SECOND_OUT), .OPR_ACK_IN(OPR_ACK_IN), .OPR_DATA_IN(OPR_DATA_IN),
    .DONE_OUT(DONE_OUT), .CCR_OUT(CCR_OUT), .TRAP_OUT(TRAP_OUT),
    .TRAP_VECTOR_OUT(TRAP_VECTOR_OUT), .ILLEGAL_OUT(ILLEGAL_OUT));
  operand_fetch_model i_mem (.clk_in(CLK_IN), .rst_in(RST_IN), .req_in(OPR_REQ_OUT),
    .mem_in(OPR_MEM_OUT), .reg_in(OPR_REG_OUT), .second_in(OPR_SECOND_OUT),
    .slow_in(slow), .ack_out(OPR_ACK_IN), .data_out(OPR_DATA_IN));
  always #5 CLK_IN = ~CLK_IN;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    PSEL_IN <= 1;
    PWRITE_IN <= wr;
    PADDR_IN <= a;
    PWDATA_IN <= wd;
    @(posedge CLK_IN);
    PENABLE_IN <= 1;
    n = 0;
    do begin @(posedge CLK_IN); n++; end while (PREADY_OUT !== 1'b1 && n < 20);
    rd = PRDATA_OUT;
    er = PSLVERR_OUT;
    PSEL_IN <= 0;
    PENABLE_IN <= 0;
    @(posedge CLK_IN);
    if (n >= 20) begin bad_count++; finish_test(); end
  endtask
  task automatic ex(input logic [15:0] op, input logic [15:0] ext, input logic [4:0] cc);
    int n;
    INSTR_VALID_IN <= 1;
    OPCODE_IN <= op;
    EXT_WORD_IN <= ext;
    CCR_IN <= cc;
    n = 0;
    do begin @(posedge CLK_IN); n++; end while (INSTR_READY_OUT !== 1'b1 && n < 99);
    INSTR_VALID_IN <= 0;
    g_done = 0;
    g_ill = 0;
    for (n = 0; n < 99 && !g_done && !g_ill; n++) begin
      @(negedge CLK_IN);
      g_done = DONE_OUT;
      g_ill = ILLEGAL_OUT;
      g_trap = TRAP_OUT;
      g_ccr = CCR_OUT;
      g_vec = TRAP_VECTOR_OUT;
    end
    if (g_done !== 1'b1 && g_ill !== 1'b1) begin bad_count++; finish_test(); end
    n_done += g_done;
    n_trap += g_trap & g_done;
    @(posedge CLK_IN);
  endtask
  task automatic bt(input logic [15:0] op, input logic [15:0] ext, input logic [4:0] cc,
                    input logic z);
    ex(op, ext, cc);
    check("bit illegal", g_ill, 0);
    check("bit ccr", g_ccr, {cc[4:3], z, cc[1:0]});
  endtask
  task automatic t_bits;
    i_mem.regs[3] = 32'h8000_0001;
    i_mem.regs[2] = 32'h0000_0021;
    i_mem.regs[5] = 32'h0000_0002;
    i_mem.mem_lo = 32'h0000_0180;
    bt(16'h0803, 16'h001F, 5'h1B, 0);
    bt(16'h0803, 16'h003F, 5'h04, 0);
    bt(16'h0803, 16'h0021, 5'h00, 1);
    bt(16'h0810, 16'h000F, 5'h1F, 0);
    bt(16'h0810, 16'h0008, 5'h0B, 1);
    bt(16'h083A, 16'h0007, 5'h00, 0);
    bt(16'h083B, 16'h0001, 5'h11, 1);
    bt(16'h0505, 16'h0000, 5'h0A, 0);
    bt(16'h053C, 16'h0000, 5'h15, 1);
    bt(16'h0510, 16'h0000, 5'h00, 1);
  endtask
  task automatic t_illegal;
    logic [31:0] tbl [10];
    tbl = '{32'h0808_0001, 32'h083C_0001, 32'h0810_0101, 32'h0508_0000, 32'h43BC_0000,
            32'h0200_1800, 32'h0218_1800, 32'h0220_1800, 32'h023C_1800, 32'h0210_1000};
    foreach (tbl[i]) begin
      ex(tbl[i][31:16], tbl[i][15:0], 5'h00);
      check("illegal", g_ill, 1);
    end
  endtask
  task automatic sc(input logic [15:0] op, input logic [31:0] v, input logic [31:0] b,
                    input logic tr, input logic n);
    i_mem.regs[1] = v;
    i_mem.regs[4] = b;
    i_mem.mem_lo = b;
    ex(op, 16'h0000, 5'h11);
    check("single trap", g_trap, tr);
    check("single vector", g_vec, tr ? `CHECK_VECTOR : 8'h00);
    check("single x", g_ccr[4], 1);
    if (tr) check("single n", g_ccr[3], n);
  endtask
  task automatic pc(input logic [1:0] sz, input logic [3:0] r, input logic [31:0] v,
                    input logic [31:0] lo, input logic [31:0] hi, input logic tr, input logic z);
    i_mem.regs[r] = v;
    i_mem.mem_lo = lo;
    i_mem.mem_hi = hi;
    ex({5'h00, sz, 9'h010}, {r, 12'h800}, 5'h1F);
    check("paired trap", g_trap, tr);
    check("paired c", g_ccr[0], tr);
    check("paired z", g_ccr[2], z);
    check("paired x", g_ccr[4], 1);
  endtask
  task automatic t_checks;
    sc(16'h4384, 32'h0000_0005, 32'h0000_000A, 0, 0);
    sc(16'h4384, 32'h0000_FFFF, 32'h0000_000A, 1, 1);
    sc(16'h4384, 32'h0000_000B, 32'h0000_000A, 1, 0);
    sc(16'h4384, 32'h0000_000A, 32'h0000_000A, 0, 0);
    sc(16'h4384, 32'h0000_0003, 32'h0000_FFFE, 1, 0);
    sc(16'h4304, 32'h8000_0000, 32'h7FFF_FFFF, 1, 1);
    sc(16'h4304, 32'h0001_0000, 32'h0002_0000, 0, 0);
    sc(16'h4390, 32'h0000_0009, 32'h0000_0008, 1, 0);
    pc(2'h0, 4'h3, 32'hFFFF_FF05, 32'h0000_0003, 32'h0000_0007, 0, 0);
    pc(2'h0, 4'h3, 32'h0000_0003, 32'h0000_0003, 32'h0000_0007, 0, 1);
    pc(2'h0, 4'h3, 32'h0000_0002, 32'h0000_0003, 32'h0000_0007, 1, 0);
    pc(2'h1, 4'h3, 32'h0000_0008, 32'h0000_0003, 32'h0000_0007, 1, 0);
    pc(2'h1, 4'h3, 32'h0000_0007, 32'h0000_0003, 32'h0000_0007, 0, 1);
    slow <= 1;
    pc(2'h2, 4'h3, 32'h0000_0005, 32'h0000_0005, 32'h0000_0005, 0, 1);
    pc(2'h2, 4'h3, 32'h0000_0006, 32'h0000_0005, 32'h0000_0005, 1, 0);
    pc(2'h1, 4'h9, 32'hFFFF_FFFE, 32'h0000_FFFC, 32'h0000_0004, 0, 0);
    pc(2'h1, 4'h9, 32'h0000_FFFE, 32'h0000_FFFC, 32'h0000_0004, 1, 0);
    slow <= 0;
  endtask
  task automatic t_regs;
    apb(0, `OFS_CTRL, 0);
    check("ctrl reset", rd, `CTRL_RESET);
    apb(1, 8'h10, 32'hFFFF_FFFF);
    check("unmapped write err", er, 1);
    apb(0, 8'h10, 0);
    check("unmapped read", {er, rd[30:0]}, 32'h8000_0000);
    apb(1, `OFS_CTRL, 0);
    repeat (2) @(negedge CLK_IN);
    check("ready when off", INSTR_READY_OUT, 0);
    @(posedge CLK_IN);
    apb(1, `OFS_CTRL, 1);
  endtask
  task automatic t_counts;
    apb(0, `OFS_EXEC_COUNT, 0);
    check("exec count", rd, n_done);
    apb(1, `OFS_TRAP_COUNT, 0);
    apb(0, `OFS_TRAP_COUNT, 0);
    check("trap count", rd, n_trap);
  endtask
  initial begin
    repeat (12) @(posedge CLK_IN);
    RST_IN <= 0;
    @(posedge CLK_IN);
    t_regs();
    t_bits();
    t_illegal();
    t_checks();
    t_counts();
    finish_test();
  end
endmodule
`default_nettype wire
